//--- dv/sar_adc_parallel_output_control_tb_top.sv
// sar_adc_parallel_output_control_tb_top: directed bench for the converter control block
// assumes: sar_adc_pkg, sar_conv_if, sar_engine and sar_adc_ctrl compiled first
`timescale 1ns/1ns
module sar_adc_parallel_output_control_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, busy_n, comp_high;
  logic [1:0] bresp, rresp;
  logic cs_n = 1'b1, rd_conv = 1'b1, byte_sel = 1'b0;
  logic [11:0] trial_code, result_line, result_line_oe_n, level = 12'h000;
  logic [3:0] zero_fill_output, zero_fill_output_oe_n;
  int err_count = 0;
  int tests_run = 0;

  // ----------------------------------------------------------------
  // clock, block and far side
  // ----------------------------------------------------------------
  always #25 aclk = ~aclk;

  sar_adc_ctrl #(.ADDR_W(8), .BIT_CYCLES(1)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .cs_n(cs_n), .rd_conv(rd_conv), .byte_sel(byte_sel),
    .comp_high(comp_high), .trial_code(trial_code), .busy_n(busy_n),
    .result_line(result_line), .result_line_oe_n(result_line_oe_n),
    .zero_fill_output(zero_fill_output), .zero_fill_output_oe_n(zero_fill_output_oe_n));

  sar_far_model u_far (.trial_code(trial_code), .level(level), .comp_high(comp_high));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge aclk);
  endtask

  // pin levels change right after a rising edge
  task automatic pins(input logic c, input logic r, input logic b);
    @(posedge aclk);
    cs_n <= c;
    rd_conv <= r;
    byte_sel <= b;
  endtask

  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (busy_n !== v && n < 300) begin
      @(negedge aclk);
      n++;
    end
    check("busy_n", {31'h0, busy_n}, {31'h0, v});
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    check("bresp", {30'h0, bresp}, {30'h0, sar_adc_pkg::RESP_OKAY});
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // one conversion with select low and a one-cycle (50 ns) convert pulse
  task automatic convert(input logic [11:0] lv);
    level = lv;
    tick(sar_adc_pkg::ACQ_CYCLES);
    pins(1'b0, 1'b0, 1'b0);
    pins(1'b0, 1'b1, 1'b0);
    wait_busy(1'b0);
    wait_busy(1'b1);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    check("oe idle", {20'h0, result_line_oe_n}, 32'hFFF);
    check("fill oe idle", {28'h0, zero_fill_output_oe_n}, 32'hF);
    axi_rd(sar_adc_pkg::OFF_CTRL, d, r);
    check("ctrl reset", d & 32'h1, 32'h1);
    axi_rd(8'h10, d, r);
    check("unmapped resp", {30'h0, r}, {30'h0, sar_adc_pkg::RESP_SLVERR});
    check("unmapped data", d, 32'h0);
  endtask

  task automatic t_codes();
    logic [11:0] codes [4];
    codes = '{12'h000, 12'h800, 12'hFFF, 12'h5A3};
    foreach (codes[i]) begin
      convert(codes[i]);
      check("data at busy rise", {20'h0, result_line}, {20'h0, codes[i]});
      check("oe after read", {20'h0, result_line_oe_n}, 32'h0);
      check("fill low", {28'h0, zero_fill_output}, 32'h0);
      check("fill oe", {28'h0, zero_fill_output_oe_n}, 32'h0);
    end
  endtask

  task automatic t_swap();
    pins(1'b0, 1'b1, 1'b1);
    tick(3);
    check("upper lane", {28'h0, result_line[11:8]}, 32'h3);
    check("low fill", {28'h0, result_line[7:4]}, 32'h0);
    check("lower lane", {28'h0, result_line[3:0]}, 32'h5);
    check("fill lane", {28'h0, zero_fill_output}, 32'hA);
    pins(1'b0, 1'b1, 1'b0);
    tick(3);
    check("natural", {20'h0, result_line}, 32'h5A3);
  endtask

  task automatic t_select();
    logic [31:0] d;
    logic [1:0] r;
    pins(1'b1, 1'b1, 1'b0);
    tick(3);
    check("cs high float", {20'h0, result_line_oe_n}, 32'hFFF);
    check("cs high fill", {28'h0, zero_fill_output_oe_n}, 32'hF);
    pins(1'b0, 1'b1, 1'b0);
    tick(3);
    check("cs fall read", {20'h0, result_line_oe_n}, 32'h0);
    pins(1'b1, 1'b0, 1'b0);
    tick(sar_adc_pkg::ACQ_CYCLES);
    level = 12'h2C7;
    pins(1'b0, 1'b0, 1'b0);
    pins(1'b1, 1'b1, 1'b0);
    wait_busy(1'b0);
    tick(2);
    check("busy float", {20'h0, result_line_oe_n}, 32'hFFF);
    wait_busy(1'b1);
    axi_rd(sar_adc_pkg::OFF_RESULT, d, r);
    check("result reg", d, 32'h2C7);
  endtask

  task automatic t_ignore();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(sar_adc_pkg::OFF_STATUS, 32'h38);
    level = 12'h123;
    tick(sar_adc_pkg::ACQ_CYCLES);
    pins(1'b0, 1'b0, 1'b0);
    pins(1'b0, 1'b1, 1'b0);
    wait_busy(1'b0);
    pins(1'b0, 1'b0, 1'b0);
    pins(1'b0, 1'b1, 1'b0);
    wait_busy(1'b1);
    tick(6);
    check("no second start", {31'h0, busy_n}, 32'h1);
    axi_rd(sar_adc_pkg::OFF_STATUS, d, r);
    check("ignored flag", (d >> sar_adc_pkg::ST_IGNORED_BIT) & 32'h1, 32'h1);
    check("status word", d, (32'h1 << sar_adc_pkg::ST_IGNORED_BIT) | 32'h2);
  endtask

  task automatic t_reconv();
    logic [31:0] d;
    logic [1:0] r;
    tick(sar_adc_pkg::ACQ_CYCLES);
    pins(1'b0, 1'b0, 1'b0);
    wait_busy(1'b0);
    wait_busy(1'b1);
    tick(3);
    check("reconversion", {31'h0, busy_n}, 32'h0);
    pins(1'b0, 1'b1, 1'b0);
    wait_busy(1'b1);
    axi_rd(sar_adc_pkg::OFF_STATUS, d, r);
    check("invalid flag", (d >> sar_adc_pkg::ST_INVALID_BIT) & 32'h1, 32'h1);
    check("short acq flag", (d >> sar_adc_pkg::ST_SHORT_BIT) & 32'h1, 32'h1);
  endtask

  task automatic t_ctrl();
    logic [31:0] d;
    logic [1:0] r;
    tick(sar_adc_pkg::ACQ_CYCLES);
    axi_wr(sar_adc_pkg::OFF_CTRL, 32'h3);
    wait_busy(1'b0);
    wait_busy(1'b1);
    axi_wr(sar_adc_pkg::OFF_CTRL, 32'h0);
    pins(1'b0, 1'b0, 1'b0);
    pins(1'b0, 1'b1, 1'b0);
    tick(5);
    check("disabled start", {31'h0, busy_n}, 32'h1);
    axi_wr(sar_adc_pkg::OFF_CTRL, 32'h1);
    axi_rd(sar_adc_pkg::OFF_COUNT, d, r);
    check("conv count", d, 32'h9);
  endtask

  // ----------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    results();
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    tick(2);
    t_reset();
    t_codes();
    t_swap();
    t_select();
    t_ignore();
    t_reconv();
    t_ctrl();
    results();
  end
endmodule // sar_adc_parallel_output_control_tb_top

//--- dv/sar_far_model.sv
// sar_far_model: comparator standing in for the analog side of the converter
// assumes: trial_code from the block, input level given as an ideal 12-bit code
`timescale 1ns/1ns
module sar_far_model (
  input wire logic [11:0] trial_code,
  input wire logic [11:0] level,
  output logic comp_high
);
  // ideal straight-binary comparator, high when the level is at or above the trial
  assign comp_high = (level >= trial_code);
endmodule // sar_far_model

//--- shared/sar_adc_pkg.sv
// sar_adc_pkg: constants shared by the converter control block and its engine
// assumes: a 20 MHz aclk and a 32-bit AXI4-Lite register bus

package sar_adc_pkg;

  // ----------------------------------------------------------------
  // result coding
  // ----------------------------------------------------------------
  localparam int RES_W = 12;
  localparam int FILL_W = 4;
  localparam logic [11:0] ZERO_CODE = 12'h000;
  localparam logic [11:0] MID_CODE = 12'h800;
  localparam logic [11:0] FULL_CODE = 12'hFFF;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_RESULT = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0C;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SWSTART_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DRIVE_BIT = 1;
  localparam int ST_BYTE_BIT = 2;
  localparam int ST_SHORT_BIT = 3;
  localparam int ST_IGNORED_BIT = 4;
  localparam int ST_INVALID_BIT = 5;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int MIN_CONV_LOW_NS = 40;
  localparam int MIN_CONV_LOW_CYCLES = (MIN_CONV_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_TIME_NS = 10000;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

//--- shared/sar_conv_if.sv
// sar_conv_if: link between the control logic and the approximation engine
// assumes: both ends run on the same aclk
`timescale 1ns/1ns
interface sar_conv_if;
  logic start;
  logic comp_high;
  logic [sar_adc_pkg::RES_W-1:0] trial;
  logic busy;
  logic done;
  logic [sar_adc_pkg::RES_W-1:0] result;

  modport ctrl(output start, output comp_high, input trial, input busy, input done,
               input result);
  modport engine(input start, input comp_high, output trial, output busy, output done,
                 output result);
endinterface

//--- verilog/sar_adc_ctrl.sv
// sar_adc_ctrl: convert/read control and three-state result output of a 12-bit converter
// assumes: pin inputs synchronous to aclk, an outside comparator answers the trial code,
// and an AXI4-Lite master that keeps one write and one read in flight at most
`timescale 1ns/1ns
module sar_adc_ctrl #(
  parameter int ADDR_W = 8,
  parameter int BIT_CYCLES = 13
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic cs_n,
  input wire logic rd_conv,
  input wire logic byte_sel,
  input wire logic comp_high,
  output logic [11:0] trial_code,
  output logic busy_n,
  output logic [11:0] result_line,
  output logic [11:0] result_line_oe_n,
  output logic [3:0] zero_fill_output,
  output logic [3:0] zero_fill_output_oe_n
);
  localparam int RES_W = sar_adc_pkg::RES_W;
  localparam int FILL_W = sar_adc_pkg::FILL_W;
  localparam int ACQ_W = $clog2(sar_adc_pkg::ACQ_CYCLES + 1);
  localparam logic [ACQ_W-1:0] ACQ_FULL = ACQ_W'(sar_adc_pkg::ACQ_CYCLES);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // engine
  // ----------------------------------------------------------------
  sar_conv_if conv ();

  sar_engine #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .conv(conv.engine)
  );

  logic start_q;
  assign conv.start = start_q;
  assign conv.comp_high = comp_high;
  assign trial_code = conv.trial;

  // ----------------------------------------------------------------
  // pin sampling and event decode
  // ----------------------------------------------------------------
  logic cs_q;
  logic rc_q;
  logic byte_q;
  logic comb_prev;
  logic retrig_q;
  logic ctrl_en;
  logic sw_start;
  logic [RES_W-1:0] out_word;
  logic [ACQ_W-1:0] acq_cnt;
  logic short_acq;
  logic ignored;
  logic invalid;
  logic [15:0] conv_count;

  // ORed control level and its falling edge
  wire comb = cs_q | rc_q;
  wire comb_fall = comb_prev & ~comb;
  wire drive = ~cs_q & rc_q;
  wire load = conv.done;
  wire converting = ~busy_n | conv.busy | start_q;
  wire cmd = ctrl_en & ((comb_fall | retrig_q) & ~comb | sw_start);
  wire start_req = cmd & ~converting;
  wire cmd_lost = cmd & converting;
  wire early = start_req & (acq_cnt != ACQ_FULL);

  // registered pin levels, one cycle of latency
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_q <= 1'b1;
      rc_q <= 1'b1;
      byte_q <= 1'b0;
      comb_prev <= 1'b1;
    end else begin
      cs_q <= cs_n;
      rc_q <= rd_conv;
      byte_q <= byte_sel;
      comb_prev <= comb;
    end
  end

  // ----------------------------------------------------------------
  // conversion control
  // ----------------------------------------------------------------
  // start pulse, busy flag and a reconversion when the level is still low at the end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= 1'b0;
      busy_n <= 1'b1;
      retrig_q <= 1'b0;
    end else begin
      start_q <= start_req;
      retrig_q <= load & ~comb;
      if (start_req) begin
        busy_n <= 1'b0;
      end else if (load) begin
        busy_n <= 1'b1;
      end
    end
  end

  // output register and completed-conversion counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_word <= sar_adc_pkg::ZERO_CODE;
      conv_count <= 16'h0000;
    end else if (load) begin
      out_word <= conv.result;
      conv_count <= conv_count + 16'h0001;
    end
  end

  // cycles since the last conversion ended, saturating at the acquisition time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acq_cnt <= ACQ_FULL;
    end else if (load) begin
      acq_cnt <= '0;
    end else if (acq_cnt != ACQ_FULL) begin
      acq_cnt <= acq_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // result lines
  // ----------------------------------------------------------------
  // lane selection on the word that the output register holds after this edge
  wire [RES_W-1:0] next_word = load ? conv.result : out_word;
  wire [RES_W-1:0] lane_word = byte_q ? {next_word[3:0], 4'h0, next_word[11:8]}
                                      : next_word;
  wire [FILL_W-1:0] lane_fill = byte_q ? next_word[7:4] : 4'h0;

  // pin drivers, enables active low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_line <= '0;
      zero_fill_output <= '0;
      result_line_oe_n <= '1;
      zero_fill_output_oe_n <= '1;
    end else begin
      result_line <= lane_word;
      zero_fill_output <= lane_fill;
      result_line_oe_n <= {RES_W{~drive}};
      zero_fill_output_oe_n <= {FILL_W{~drive}};
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  wire aw_hs = awvalid & awready;
  wire w_hs = wvalid & wready;
  wire wr_go = aw_held & w_held & ~bvalid;
  wire [7:0] wr_off = 8'(wr_addr);
  wire [7:0] rd_off = 8'(araddr);
  wire wr_ctrl = wr_go & (wr_off == sar_adc_pkg::OFF_CTRL) & wr_strb[0];
  wire wr_status = wr_go & (wr_off == sar_adc_pkg::OFF_STATUS) & wr_strb[0];
  wire wr_ok = (wr_off == sar_adc_pkg::OFF_CTRL) | (wr_off == sar_adc_pkg::OFF_STATUS);
  wire [2:0] clr_mask = wr_status ? wr_data[5:3] : 3'h0;

  // write address and data are taken in either order, then answered together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= sar_adc_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_held <= 1'b1;
        awready <= 1'b0;
        wr_addr <= awaddr;
      end
      if (w_hs) begin
        w_held <= 1'b1;
        wready <= 1'b0;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? sar_adc_pkg::RESP_OKAY : sar_adc_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // control register; the software start is a one-cycle command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_en <= sar_adc_pkg::CTRL_EN_RESET;
      sw_start <= 1'b0;
    end else begin
      sw_start <= wr_ctrl & wr_data[sar_adc_pkg::CTRL_SWSTART_BIT];
      if (wr_ctrl) begin
        ctrl_en <= wr_data[sar_adc_pkg::CTRL_EN_BIT];
      end
    end
  end

  // sticky status flags, write one to clear, a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      short_acq <= 1'b0;
      ignored <= 1'b0;
      invalid <= 1'b0;
    end else begin
      short_acq <= early | (short_acq & ~clr_mask[0]);
      ignored <= cmd_lost | (ignored & ~clr_mask[1]);
      invalid <= (start_req & retrig_q) | (invalid & ~clr_mask[2]);
    end
  end

  // read data selection
  wire [31:0] status_word = {26'h0, invalid, ignored, short_acq, byte_q, drive, ~busy_n};
  wire [31:0] ctrl_word = {31'h0, ctrl_en};
  wire rd_ok = (rd_off == sar_adc_pkg::OFF_CTRL) | (rd_off == sar_adc_pkg::OFF_STATUS) |
               (rd_off == sar_adc_pkg::OFF_RESULT) | (rd_off == sar_adc_pkg::OFF_COUNT);
  wire [31:0] rd_mux =
    (rd_off == sar_adc_pkg::OFF_CTRL) ? ctrl_word :
    (rd_off == sar_adc_pkg::OFF_STATUS) ? status_word :
    (rd_off == sar_adc_pkg::OFF_RESULT) ? {20'h0, out_word} :
    (rd_off == sar_adc_pkg::OFF_COUNT) ? {16'h0, conv_count} : 32'h0000_0000;

  // read channel, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= sar_adc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_ok ? sar_adc_pkg::RESP_OKAY : sar_adc_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_LINES_FLOAT: assert property (
    (cs_q | ~rc_q) |=> (result_line_oe_n == 12'hFFF && zero_fill_output_oe_n == 4'hF))
    else $error("result lines driven while deselected");

  AST_FILL_DRIVEN: assert property (
    (~cs_q & rc_q) |=> (zero_fill_output_oe_n == 4'h0 && result_line_oe_n == 12'h000))
    else $error("lines not driven while selected for read");

  AST_BYTE_LOW: assert property (
    (!byte_q && !load) |=> (result_line == $past(out_word) && zero_fill_output == 4'h0))
    else $error("natural order word wrong");

  AST_BYTE_HIGH: assert property (
    (byte_q && !load) |=> (result_line == {$past(out_word[3:0]), 4'h0, $past(out_word[11:8])}
      && zero_fill_output == $past(out_word[7:4])))
    else $error("swapped lanes wrong");

  AST_START_ON_FALL: assert property (
    (ctrl_en && comb_fall && busy_n && !conv.busy && !start_q) |=> (start_q && !busy_n))
    else $error("falling control level did not start a conversion");

  AST_BUSY_STAYS_LOW: assert property (
    (!busy_n && !load) |=> !busy_n)
    else $error("busy rose before the output register was loaded");

  AST_DATA_AT_RISE: assert property (
    load |=> (busy_n && out_word == $past(conv.result)
      && result_line == ($past(byte_q) ? {out_word[3:0], 4'h0, out_word[11:8]} : out_word)
      && zero_fill_output == ($past(byte_q) ? out_word[7:4] : 4'h0)))
    else $error("result not in place when busy rose");

  AST_ORED_LEVEL: assert property (
    comb == $past(cs_n | rd_conv))
    else $error("control level does not follow the sampled select and read/convert");

  AST_IGNORE_BUSY: assert property (
    (!busy_n && !load) |=> !start_q)
    else $error("convert command accepted during conversion");

  AST_RETRIGGER: assert property (
    (load && !comb && ctrl_en) |=> ##1 (start_q && invalid))
    else $error("level held low at busy rise did not reconvert");

  AST_WRITE_RESP_HOLD: assert property ( // register bus response hold
    (bvalid && !bready) |=> (bvalid && $stable(bresp)))
    else $error("write response dropped before it was taken");

endmodule // sar_adc_ctrl

//--- verilog/sar_engine.sv
// sar_engine: successive-approximation loop, one result bit per BIT_CYCLES cycles
// assumes: comp_high is high when the input is at or above the trial code
`timescale 1ns/1ns
module sar_engine #(
  parameter int BIT_CYCLES = 13
) (
  input wire logic aclk,
  input wire logic aresetn,
  sar_conv_if.engine conv
);
  localparam int RES_W = sar_adc_pkg::RES_W;
  localparam int IDX_W = $clog2(RES_W);
  localparam int CYC_W = $clog2(BIT_CYCLES + 1);

  typedef enum {ST_IDLE, ST_RUN} eng_state_t;
  eng_state_t state;
  logic [IDX_W-1:0] bit_idx;
  logic [CYC_W-1:0] cyc;

  // ----------------------------------------------------------------
  // trial decode
  // ----------------------------------------------------------------
  wire bit_end = (cyc == CYC_W'(BIT_CYCLES - 1));
  wire last_bit = (bit_idx == '0);
  wire [RES_W-1:0] cur_mask = RES_W'(1) << bit_idx;
  wire [RES_W-1:0] decided = conv.comp_high ? conv.trial : (conv.trial & ~cur_mask);
  wire [RES_W-1:0] next_trial = last_bit ? decided : (decided | (cur_mask >> 1));

  // bit loop, straight binary starting from midscale
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      bit_idx <= '0;
      cyc <= '0;
      conv.trial <= sar_adc_pkg::MID_CODE;
      conv.busy <= 1'b0;
      conv.done <= 1'b0;
      conv.result <= sar_adc_pkg::ZERO_CODE;
    end else begin
      conv.done <= 1'b0;
      case (state)
        ST_IDLE: if (conv.start) begin
          state <= ST_RUN;
          conv.trial <= sar_adc_pkg::MID_CODE;
          bit_idx <= IDX_W'(RES_W - 1);
          cyc <= '0;
          conv.busy <= 1'b1;
        end
        ST_RUN: if (bit_end) begin
          cyc <= '0;
          conv.trial <= next_trial;
          if (last_bit) begin
            state <= ST_IDLE;
            conv.busy <= 1'b0;
            conv.done <= 1'b1;
            conv.result <= decided;
          end else begin
            bit_idx <= bit_idx - 1'b1;
          end
        end else begin
          cyc <= cyc + 1'b1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  AST_MID_FIRST: assert property (@(posedge aclk) disable iff (!aresetn)
    (conv.start && state == ST_IDLE) |=> (conv.trial == sar_adc_pkg::MID_CODE && conv.busy))
    else $error("first trial is not midscale");

endmodule // sar_engine
